/* design/pwm_prescaler.v */
// Prescale divider: one-cycle tick every (factor + 1) clocks.
// Assumes factor comes from the register file; a new factor applies at once.
`timescale 1ns/100ps
`default_nettype none
module pwm_prescaler #(
   parameter WIDTH = 6
) (
   // Clock and reset
   input wire ref_clk,
   input wire reset,
   // Control
   input wire run,
   input wire [WIDTH-1:0] factor,
   // Tick output
   output wire tick
);
   reg [WIDTH-1:0] count_r;
   reg [WIDTH-1:0] count_nxt;

   // Tick fires when the count reaches the factor
   assign tick = run && (count_r >= factor);

   // Count up and wrap; >= keeps a lowered factor from stalling the tick
   always @*
   begin
      count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
      if (!run || tick)
      begin
         count_nxt = {WIDTH{1'b0}};
      end
   end

   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         count_r <= {WIDTH{1'b0}};
      end
      else
      begin
         count_r <= count_nxt;
      end
   end
endmodule
`default_nettype wire

/* design/pwm_regs.vh */
// Register offsets, field positions, reset values and period constants for the PWM block.
// Assumes the including file sits on an 8-bit special function register port of the core.
//
// Functional notes
// - Mode 00: module idle, output held low
// - Mode 01: period 63 ticks, six duty bits
// - Mode 10: period 127 ticks, seven duty bits
// - Mode 11: period 255 ticks, eight duty bits
// - Low six control bits prescale tick rate
// - Duty write takes effect immediately
// - Transitional period average between old, new
// - Duty bits used follow period length
`ifndef PWM_REGS_VH
`define PWM_REGS_VH

// ***********************************************
// Register map
// ***********************************************
`define PWM_PERIOD_CONTROL_ADDR 8'hA9
`define PWM_DUTY_SETTING_ADDR 8'hAA
`define PWM_PERIOD_CONTROL_RESET 8'h00
`define PWM_DUTY_SETTING_RESET 8'h00

// ***********************************************
// Fields of the control register
// ***********************************************
`define PWM_MODE_HI 7
`define PWM_MODE_LO 6
`define PWM_PRESCALE_HI 5
`define PWM_PRESCALE_LO 0

// ***********************************************
// Mode codes and period lengths in ticks
// ***********************************************
`define PWM_MODE_OFF 2'h0
`define PWM_MODE_6BIT 2'h1
`define PWM_MODE_7BIT 2'h2
`define PWM_MODE_8BIT 2'h3
`define PWM_PERIOD_6BIT 8'h3F
`define PWM_PERIOD_7BIT 8'h7F
`define PWM_PERIOD_8BIT 8'hFF

`endif

/* design/single_channel_pwm.v */
// Single-channel PWM with two 8-bit special function registers.
// Holds the register file, the read port, the duty mask and the phase counter.
// Assumes a core SFR port: sfr_addr with one-cycle write and read strobes, same clock.
// Assumes the crystal clock drives ref_clk and the core reset is synchronous to it.
`timescale 1ns/100ps
`default_nettype none
`include "pwm_regs.vh"
module single_channel_pwm (
   // Clock and reset
   input wire ref_clk,
   input wire reset,
   // Special function register port
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   output reg sfr_hit,
   // PWM output
   output reg pwm_out
);
   // ***********************************************
   // Registers
   // ***********************************************
   reg [7:0] pwm_period_control_r;
   reg [7:0] pwm_duty_setting_r;
   reg [7:0] phase_r;
   reg [7:0] phase_nxt;
   reg [7:0] duty_used;
   reg [7:0] sfr_rdata_nxt;
   reg pwm_nxt;
   wire [1:0] mode;
   wire [5:0] prescale;
   wire running;
   wire tick;
   wire [7:0] last_phase;
   wire sel_control;
   wire sel_duty;

   // ***********************************************
   // Decode helpers
   // ***********************************************
   // Address compare for the control register, used by writes and reads
   function is_control_addr;
      input [7:0] addr;
   begin
      is_control_addr = (addr == `PWM_PERIOD_CONTROL_ADDR);
   end
   endfunction

   // Address compare for the duty register, used by writes and reads
   function is_duty_addr;
      input [7:0] addr;
   begin
      is_duty_addr = (addr == `PWM_DUTY_SETTING_ADDR);
   end
   endfunction

   // Last phase of a period; an idle mode parks the counter at zero
   function [7:0] period_last;
      input [1:0] sel;
   begin
      case (sel)
         `PWM_MODE_6BIT:
         begin
            period_last = `PWM_PERIOD_6BIT - 8'h01;
         end
         `PWM_MODE_7BIT:
         begin
            period_last = `PWM_PERIOD_7BIT - 8'h01;
         end
         `PWM_MODE_8BIT:
         begin
            period_last = `PWM_PERIOD_8BIT - 8'h01;
         end
         default:
         begin
            period_last = 8'h00;
         end
      endcase
   end
   endfunction

   // Control fields; mode zero idles the divider, phase counter and output, registers stay live
   assign mode = pwm_period_control_r[`PWM_MODE_HI:`PWM_MODE_LO];
   assign prescale = pwm_period_control_r[`PWM_PRESCALE_HI:`PWM_PRESCALE_LO];
   assign running = (mode != `PWM_MODE_OFF);
   assign last_phase = period_last(mode);

   // One decode shared by the write and read paths keeps them in step
   assign sel_control = is_control_addr(sfr_addr);
   assign sel_duty = is_duty_addr(sfr_addr);

   // ***********************************************
   // Register file
   // ***********************************************
   // Register writes; the duty value is used live, so no shadow copy
   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         pwm_period_control_r <= `PWM_PERIOD_CONTROL_RESET;
         pwm_duty_setting_r <= `PWM_DUTY_SETTING_RESET;
      end
      else if (sfr_wr)
      begin
         if (sel_control)
         begin
            pwm_period_control_r <= sfr_wdata;
         end
         if (sel_duty)
         begin
            pwm_duty_setting_r <= sfr_wdata;
         end
      end
   end

   // ***********************************************
   // Read port
   // ***********************************************
   // Read mux, registered; other addresses answer zero with no hit
   always @*
   begin
      sfr_rdata_nxt = 8'h00;
      if (sel_control)
      begin
         sfr_rdata_nxt = pwm_period_control_r;
      end
      else if (sel_duty)
      begin
         sfr_rdata_nxt = pwm_duty_setting_r;
      end
   end

   // Data and hit stand one cycle after the strobe, zero otherwise
   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         sfr_rdata <= 8'h00;
         sfr_hit <= 1'b0;
      end
      else
      begin
         sfr_rdata <= sfr_rd ? sfr_rdata_nxt : 8'h00;
         sfr_hit <= sfr_rd && (sel_control || sel_duty);
      end
   end

   // ***********************************************
   // Tick divider
   // ***********************************************
   // One tick every prescale plus one clocks; it idles while the mode is off
   pwm_prescaler #(
      .WIDTH(6)
   ) u_prescaler (
      .ref_clk(ref_clk),
      .reset(reset),
      .run(running),
      .factor(prescale),
      .tick(tick)
   );

   // ***********************************************
   // Duty mask
   // ***********************************************
   // Mask duty to the bits that the period length uses
   always @*
   begin
      case (mode)
         `PWM_MODE_6BIT:
         begin
            duty_used = {2'h0, pwm_duty_setting_r[5:0]};
         end
         `PWM_MODE_7BIT:
         begin
            duty_used = {1'b0, pwm_duty_setting_r[6:0]};
         end
         `PWM_MODE_8BIT:
         begin
            duty_used = pwm_duty_setting_r;
         end
         default:
         begin
            duty_used = 8'h00;
         end
      endcase
   end

   // ***********************************************
   // Phase counter and output
   // ***********************************************
   // Phase counter: period-length phases, each one prescaled tick long.
   // A change between running modes keeps the phase; a phase past the new end wraps next tick.
   // Counter keeps running across duty writes, so a write only moves the
   // compare edge; the transitional period averages between old and new.
   always @*
   begin
      phase_nxt = phase_r;
      if (!running)
      begin
         phase_nxt = 8'h00;
      end
      else if (tick)
      begin
         phase_nxt = (phase_r >= last_phase) ? 8'h00 : phase_r + 8'h01;
      end
      pwm_nxt = running && (phase_nxt < duty_used);
   end

   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         phase_r <= 8'h00;
         pwm_out <= 1'b0;
      end
      else
      begin
         phase_r <= phase_nxt;
         pwm_out <= pwm_nxt;
      end
   end
endmodule
`default_nettype wire

/* sim/pwm_properties.sv */
// Checker on the PWM block ports: register reads and output level.
// Assumes a bind onto single_channel_pwm; it shadows both registers.
`timescale 1ns/100ps
`default_nettype none
module pwm_properties (
   // Clock, reset, register port, output
   input wire ref_clk,
   input wire reset,
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   input wire [7:0] sfr_rdata,
   input wire sfr_hit,
   input wire pwm_out
);
   // ****
   // Shadow registers and checks
   // ****
   reg [7:0] ctl_r;
   reg [7:0] dut_r;
   wire [1:0] mode = ctl_r[7:6];
   // High duty bits beyond the period length are ignored
   wire [7:0] md = dut_r & (mode == 2'h1 ? 8'h3F : mode == 2'h2 ? 8'h7F : 8'hFF);
   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         ctl_r <= 8'h00;
         dut_r <= 8'h00;
      end
      else if (sfr_wr && sfr_addr == 8'hA9)
         ctl_r <= sfr_wdata;
      else if (sfr_wr && sfr_addr == 8'hAA)
         dut_r <= sfr_wdata;
   end
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   // Duty write then a quiet cycle; the registered output shows it one edge later
   sequence s_dw(v);
      sfr_wr && sfr_addr == 8'hAA && sfr_wdata == v ##1 !sfr_wr;
   endsequence
   a_read_ctl: assert property (sfr_rd && sfr_addr == 8'hA9
      |=> sfr_hit && sfr_rdata == $past(ctl_r)) else $error("control read wrong");
   a_read_duty: assert property (sfr_rd && sfr_addr == 8'hAA
      |=> sfr_hit && sfr_rdata == $past(dut_r)) else $error("duty read wrong");
   a_read_miss: assert property (sfr_rd && sfr_addr != 8'hA9 && sfr_addr != 8'hAA
      |=> !sfr_hit && sfr_rdata == 8'h00) else $error("unmapped read answered");
   a_read_idle: assert property (!sfr_rd |=> !sfr_hit && sfr_rdata == 8'h00)
      else $error("read data without read");
   a_off_low: assert property (mode == 2'h0 && $past(mode) == 2'h0 |-> !pwm_out)
      else $error("output high while off");
   a_zero_low: assert property ($past(md) == 8'h00 |-> !pwm_out)
      else $error("output high at zero duty");
   a_duty_drop: assert property (s_dw(8'h00) |=> !pwm_out)
      else $error("duty clear too slow");
   a_duty_rise: assert property (mode != 2'h0 ##0 s_dw(8'hFF) |=> pwm_out)
      else $error("full duty too slow");
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Bench for the PWM block: register tasks, period and duty checks.
// Assumes pwm_properties is compiled first; bound at the foot.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   reg ref_clk = 1'b0;
   reg reset = 1'b1;
   reg [7:0] sfr_addr = 8'h00;
   reg sfr_wr = 1'b0;
   reg sfr_rd = 1'b0;
   reg [7:0] sfr_wdata = 8'h00;
   wire [7:0] sfr_rdata;
   wire sfr_hit;
   wire pwm_out;
   integer n_fail = 0;
   integer compares = 0;
   always #5 ref_clk = ~ref_clk;
   single_channel_pwm single_channel_pwm_i (.ref_clk, .reset, .sfr_addr, .sfr_wr,
      .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit, .pwm_out);
   task chk(input string nm, input [15:0] got, input [15:0] exp);
   begin
      compares = compares + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("MISMATCH %s exp %0h got %0h", nm, exp, got);
      end
   end
   endtask
   task wr(input [7:0] a, input [7:0] d);
   begin
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
      @(posedge ref_clk);
   end
   endtask
   // Read data stands one cycle, so it is taken just after the read edge
   task rd(input [7:0] a, input [8:0] e);
   begin
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge ref_clk);
      sfr_rd <= 1'b0;
      #1 chk("read", {7'h0, sfr_hit, sfr_rdata}, {7'h0, e});
      @(posedge ref_clk);
   end
   endtask
   task lvl(input e);
   begin
      @(posedge ref_clk);
      #1 chk("level", {15'h0, pwm_out}, {15'h0, e});
      @(posedge ref_clk);
   end
   endtask
   // First rise after a write may be partial, so time the second full period
   task meas(input [15:0] ep, input [15:0] eh);
      integer r, t, h;
      reg pv;
   begin
      r = 0;
      t = 0;
      h = 0;
      pv = 1'b1;
      while (r < 3)
      begin
         @(posedge ref_clk);
         #1;
         if (pwm_out === 1'b1 && pv === 1'b0)
         begin
            if (r == 2)
            begin
               chk("period", t[15:0], ep);
               chk("high", h[15:0], eh);
            end
            r = r + 1;
            t = 0;
            h = 0;
         end
         t = t + 1;
         h = h + pwm_out;
         pv = pwm_out;
      end
      @(posedge ref_clk);
   end
   endtask
   task finish_test;
   begin
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   // Watchdog well past the few thousand cycles the tests need
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail = n_fail + 1;
      finish_test;
   end
   initial
   begin
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      rd(8'hA9, 9'h100);
      rd(8'hAA, 9'h100);
      wr(8'hAB, 8'h5A);
      rd(8'hAB, 9'h000);
      $display("registers done");
      wr(8'hAA, 8'h45);
      wr(8'hA9, 8'h40);
      meas(16'h3F, 16'h5);
      wr(8'hAA, 8'h85);
      wr(8'hA9, 8'h81);
      meas(16'h7F * 16'h2, 16'h5 * 16'h2);
      wr(8'hA9, 8'hC2);
      meas(16'hFF * 16'h3, 16'h85 * 16'h3);
      rd(8'hA9, 9'h1C2);
      $display("periods done");
      wr(8'hAA, 8'hFF);
      lvl(1'b1);
      wr(8'hAA, 8'h00);
      lvl(1'b0);
      wr(8'hAA, 8'hFF);
      wr(8'hA9, 8'h00);
      lvl(1'b0);
      rd(8'hA9, 9'h100);
      rd(8'hAA, 9'h1FF);
      $display("updates done");
      finish_test;
   end
endmodule
bind single_channel_pwm pwm_properties pwm_properties_i (.ref_clk, .reset, .sfr_addr,
   .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit, .pwm_out);
`default_nettype wire
